// ===== logic/ora_option_access.sv
// option register bank reached through an index and data window
`timescale 1ns/1ps
module ora_option_access (
  input  wire logic          clock_in,
  input  wire logic          rst_in,
  // register bus from the core
  input  wire ora_pkg::ora_sfr_s sfr_in,
  // option sources sampled while loading
  input  wire logic [7:0]    flash_ctm0_in,
  input  wire logic [7:0]    flash_ctm1_in,
  input  wire logic [7:0]    factory_trim_in,
  // in-application programming request
  input  wire logic          boot_mode_in,
  input  wire logic          iap_req_in,
  input  wire logic [14:0]   iap_addr_in,
  // read data, programming gate and load status
  output logic [7:0]         sfr_rdata_out,
  output logic               iap_allow_out,
  output logic               load_done_out,
  // option fields
  output logic               debug_port_disable_out,
  output logic               boot_from_loader_out,
  output logic [14:0]        app_end_out,
  output logic [7:0]         oscillator_trim_out,
  output logic [3:0]         clock_divide_out,
  output logic               watchdog_enable_option_out,
  output logic               crystal_enable_out,
  output logic               ext_reset_disable_out,
  output logic               lvr_disable_out,
  output logic [1:0]         lvr_level_out,
  output logic [1:0]         vref_select_out
);
  ora_pkg::ora_regs_s r;
  ora_pkg::ora_regs_s next_r;
  logic [1:0]  self_program_range;
  logic [1:0]  loader_area_size;
  logic [14:0] app_end;
  logic        in_app;
  logic        range_ok;
  logic [7:0]  selected;
  logic [14:0] loader_base;
  logic        loader_present;
  logic        in_loader;
  logic        range_open;
  logic [14:0] range_base;
  logic        running;
  logic        take_rd;
  logic        take_wr;
  logic        sel_ctm0;
  logic        sel_ctm1;
  logic        sel_trim;
  logic        hit_index;
  logic        hit_window;
  logic        rd_index;
  logic        rd_window;
  logic        wr_index;
  logic        wr_ctm0;
  logic        wr_ctm1;
  logic        wr_trim;

  assign self_program_range = r.ctm1[ora_pkg::ORA_RANGE_LSB +: 2];
  assign loader_area_size   = r.ctm1[ora_pkg::ORA_LOADER_AREA_SIZE_LSB +: 2];

  // application area end and loader area from the loader area size
  always_comb begin
    case (loader_area_size)
      2'h0: begin
        app_end        = ora_pkg::ORA_APP_END_NONE;
        loader_present = 1'b0;
        loader_base    = ora_pkg::ORA_FLASH_TOP;
      end
      2'h1: begin
        app_end        = ora_pkg::ORA_APP_END_1K;
        loader_present = 1'b1;
        loader_base    = ora_pkg::ORA_LAST_1K_BASE;
      end
      2'h2: begin
        app_end        = ora_pkg::ORA_APP_END_2K;
        loader_present = 1'b1;
        loader_base    = ora_pkg::ORA_LAST_2K_BASE;
      end
      default: begin
        app_end        = ora_pkg::ORA_APP_END_4K;
        loader_present = 1'b1;
        loader_base    = ora_pkg::ORA_APP_END_4K + 15'h0001;
      end
    endcase
  end

  // loader area is never writable, whatever the mode or range
  always_comb begin
    in_loader = loader_present && (iap_addr_in >= loader_base);
    in_app    = !in_loader && (iap_addr_in <= app_end);
  end

  // lowest address that the range field opens to in-application writes
  always_comb begin
    case (self_program_range)
      2'h0: begin
        range_open = 1'b0;
        range_base = ora_pkg::ORA_FLASH_TOP;
      end
      2'h1: begin
        range_open = 1'b1;
        range_base = ora_pkg::ORA_LAST_1K_BASE;
      end
      2'h2: begin
        range_open = 1'b1;
        range_base = ora_pkg::ORA_LAST_2K_BASE;
      end
      default: begin
        range_open = 1'b1;
        range_base = 15'h0000;
      end
    endcase
    range_ok = range_open && (iap_addr_in >= range_base);
  end

  // boot loader ignores the range field but never the loader fence
  always_comb begin
    iap_allow_out = 1'b0;
    if (iap_req_in && in_app) begin
      if (boot_mode_in) begin
        iap_allow_out = 1'b1;
      end else if (range_ok) begin
        iap_allow_out = 1'b1;
      end
    end
  end

  // accesses count only once the options are loaded
  always_comb begin
    running = r.state == ora_pkg::ORA_ST_RUN;
    take_rd = running && sfr_in.rd;
    take_wr = running && sfr_in.wr;
  end

  // index decode of the register behind the window
  always_comb begin
    sel_ctm0 = 1'b0;
    sel_ctm1 = 1'b0;
    sel_trim = 1'b0;
    if (r.index == ora_pkg::ORA_INX_CTM0) begin
      sel_ctm0 = 1'b1;
    end else if (r.index == ora_pkg::ORA_INX_CTM1) begin
      sel_ctm1 = 1'b1;
    end else if (r.index == ora_pkg::ORA_INX_TRIM) begin
      sel_trim = 1'b1;
    end
  end

  // register bus strobes split per target
  always_comb begin
    hit_index  = 1'b0;
    hit_window = 1'b0;
    if (sfr_in.addr == ora_pkg::ORA_ADDR_INDEX) begin
      hit_index = 1'b1;
    end else if (sfr_in.addr == ora_pkg::ORA_ADDR_WINDOW) begin
      hit_window = 1'b1;
    end
    rd_index  = take_rd && hit_index;
    rd_window = take_rd && hit_window;
    wr_index  = take_wr && hit_index;
    wr_ctm0   = 1'b0;
    wr_ctm1   = 1'b0;
    wr_trim   = 1'b0;
    if (take_wr && hit_window) begin
      if (sel_ctm0) begin
        wr_ctm0 = 1'b1;
      end else if (sel_ctm1) begin
        wr_ctm1 = 1'b1;
      end else if (sel_trim) begin
        wr_trim = 1'b1;
      end
    end
  end

  // selected option register, no side effects on read
  always_comb begin
    selected = 8'h00;
    if (sel_ctm0) begin
      selected = r.ctm0;
    end else if (sel_ctm1) begin
      selected = r.ctm1;
    end else if (sel_trim) begin
      selected = r.trim;
    end
  end

  always_comb begin
    next_r = r;
    case (r.state)
      ora_pkg::ORA_ST_RESET: begin
        next_r.state = ora_pkg::ORA_ST_LOAD;
      end
      ora_pkg::ORA_ST_LOAD: begin
        next_r.ctm0  = flash_ctm0_in;
        next_r.ctm1  = flash_ctm1_in;
        next_r.trim  = factory_trim_in;
        next_r.state = ora_pkg::ORA_ST_RUN;
      end
      ora_pkg::ORA_ST_RUN: begin
        if (rd_index) begin
          next_r.rdata = r.index;
        end else if (rd_window) begin
          next_r.rdata = selected;
        end else if (take_rd) begin
          next_r.rdata = 8'h00;
        end
        if (wr_index) begin
          next_r.index = sfr_in.wdata;
        end
        if (wr_ctm0) begin
          next_r.ctm0 = sfr_in.wdata;
        end
        if (wr_ctm1) begin
          next_r.ctm1 = sfr_in.wdata;
        end
        if (wr_trim) begin
          next_r.trim = sfr_in.wdata;
        end
      end
      default: begin
        next_r.state = ora_pkg::ORA_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      r.state <= ora_pkg::ORA_ST_RESET;
      r.index <= ora_pkg::ORA_INDEX_RESET;
      r.ctm0  <= ora_pkg::ORA_OPT_RESET;
      r.ctm1  <= ora_pkg::ORA_OPT_RESET;
      r.trim  <= ora_pkg::ORA_OPT_RESET;
      r.rdata <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  // clock divider selection for 32/16/8/2.66 MHz
  always_comb begin
    case (r.ctm0[ora_pkg::ORA_SCLK_LSB +: 2])
      ora_pkg::ORA_CLKDIV_1: begin
        clock_divide_out = ora_pkg::ORA_DIV_1;
      end
      ora_pkg::ORA_CLKDIV_2: begin
        clock_divide_out = ora_pkg::ORA_DIV_2;
      end
      ora_pkg::ORA_CLKDIV_4: begin
        clock_divide_out = ora_pkg::ORA_DIV_4;
      end
      default: begin
        clock_divide_out = ora_pkg::ORA_DIV_12;
      end
    endcase
  end

  // register bus and load status
  always_comb begin
    sfr_rdata_out = r.rdata;
    load_done_out = running;
    app_end_out   = app_end;
  end

  // debug port, boot and reference fields of code option register one
  always_comb begin
    debug_port_disable_out = r.ctm1[ora_pkg::ORA_DBGDIS_BIT];
    boot_from_loader_out   = r.ctm1[ora_pkg::ORA_BOOT_BIT];
    vref_select_out        = r.ctm1[ora_pkg::ORA_VREF_LSB +: 2];
  end

  // fast oscillator trim word
  always_comb begin
    oscillator_trim_out = r.trim;
  end

  // supervisory fields of code option register zero
  always_comb begin
    watchdog_enable_option_out = r.ctm0[ora_pkg::ORA_WDT_BIT];
    crystal_enable_out         = r.ctm0[ora_pkg::ORA_XTL_BIT];
    ext_reset_disable_out      = r.ctm0[ora_pkg::ORA_RSTDIS_BIT];
    lvr_disable_out            = r.ctm0[ora_pkg::ORA_LVRDIS_BIT];
    lvr_level_out              = r.ctm0[ora_pkg::ORA_LVRS_LSB +: 2];
  end
endmodule : ora_option_access

// ===== logic/ora_pkg.sv
// constants and types for the option register access block
// Summary of operation
// - When the debug port disable bit is 1 the debug pins are released to normal use.
// - The self-programming range field allows in-application writes nowhere, last 1K, last 2K or everywhere.
// - In boot loader mode the range field is ignored and the whole application area may be written.
// - Any in-application write that targets the loader area is always rejected.
// - Loader size 00 gives no loader area and an application area of 0000h to 7fffh.
// - Loader size 01 gives a last-1K loader area and an application area ending at 7bffh.
// - Loader size 10 gives a last-2K loader area and an application area ending at 77ffh.
// - Loader size 11 gives a last-4K loader area and an application area ending at 6fffh.
// - Each trim step moves the clock by about 0.18 percent, upward for larger values.
// - With the factory trim the divider option gives 32, 16, 8 or 2.66MHz.
// - The index register selects an option register and the data window reads or writes it.
// - Index c1h selects code option register zero for read-modify-write through the window.
// - On reset the option registers are loaded from the dedicated flash option area.
package ora_pkg;
  localparam logic [7:0]  ORA_ADDR_INDEX   = 8'hfe;
  localparam logic [7:0]  ORA_ADDR_WINDOW  = 8'hff;
  localparam logic [7:0]  ORA_INX_CTM0     = 8'hc1;
  localparam logic [7:0]  ORA_INX_CTM1     = 8'hc2;
  localparam logic [7:0]  ORA_INX_TRIM     = 8'h83;
  localparam logic [7:0]  ORA_INDEX_RESET  = 8'h00;
  localparam logic [7:0]  ORA_OPT_RESET    = 8'h00;
  localparam int          ORA_WDT_BIT      = 7;
  localparam int          ORA_XTL_BIT      = 6;
  localparam int          ORA_SCLK_LSB     = 4;
  localparam int          ORA_RSTDIS_BIT   = 3;
  localparam int          ORA_LVRDIS_BIT   = 2;
  localparam int          ORA_LVRS_LSB     = 0;
  localparam int          ORA_VREF_LSB     = 6;
  localparam int          ORA_BOOT_BIT     = 5;
  localparam int          ORA_DBGDIS_BIT   = 4;
  localparam int          ORA_RANGE_LSB    = 2;
  localparam int          ORA_LOADER_AREA_SIZE_LSB   = 0;
  localparam logic [14:0] ORA_FLASH_TOP    = 15'h7fff;
  localparam logic [14:0] ORA_APP_END_NONE = 15'h7fff;
  localparam logic [14:0] ORA_APP_END_1K   = 15'h7bff;
  localparam logic [14:0] ORA_APP_END_2K   = 15'h77ff;
  localparam logic [14:0] ORA_APP_END_4K   = 15'h6fff;
  localparam logic [14:0] ORA_LAST_1K_BASE = 15'h7c00;
  localparam logic [14:0] ORA_LAST_2K_BASE = 15'h7800;
  localparam logic [1:0]  ORA_CLKDIV_1     = 2'h0;
  localparam logic [1:0]  ORA_CLKDIV_2     = 2'h1;
  localparam logic [1:0]  ORA_CLKDIV_4     = 2'h2;
  localparam logic [3:0]  ORA_DIV_1        = 4'h1;
  localparam logic [3:0]  ORA_DIV_2        = 4'h2;
  localparam logic [3:0]  ORA_DIV_4        = 4'h4;
  localparam logic [3:0]  ORA_DIV_12       = 4'hc;

  typedef enum logic [2:0] {
    ORA_ST_RESET = 3'b001,
    ORA_ST_LOAD  = 3'b010,
    ORA_ST_RUN   = 3'b100
  } ora_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ora_sfr_s;

  typedef struct packed {
    ora_state_e state;
    logic [7:0] index;
    logic [7:0] ctm0;
    logic [7:0] ctm1;
    logic [7:0] trim;
    logic [7:0] rdata;
  } ora_regs_s;
endpackage : ora_pkg

// ===== verif/ora_core_model.sv
// processor core model issuing option register accesses
`timescale 1ns/1ps
module ora_core_model (
  input  wire logic        clock_in,
  input  wire logic [7:0]  rdata_in,
  output ora_pkg::ora_sfr_s sfr_out
);
  initial sfr_out = '0;
  // one-cycle strobe, then the strobes drop and the bus shows the inverse address and data of the last access
  // indices written come only from the defined option set
  task automatic access(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
    @(negedge clock_in);
    sfr_out = {w, !w, a, d};
    @(negedge clock_in);
    q = rdata_in;
    sfr_out = {2'b00, ~a, ~d};
  endtask : access
endmodule : ora_core_model

// ===== verif/ora_option_access_props.sv
// assertions on the option register access ports
`timescale 1ns/1ps
module ora_option_access_props (
  input wire logic              clock_in,
  input wire logic              rst_in,
  input wire ora_pkg::ora_sfr_s sfr_in,
  input wire logic              boot_mode_in,
  input wire logic              iap_req_in,
  input wire logic [14:0]       iap_addr_in,
  input wire logic [7:0]        factory_trim_in,
  input wire logic [7:0]        sfr_rdata_out,
  input wire logic              iap_allow_out,
  input wire logic              load_done_out,
  input wire logic [14:0]       app_end_out,
  input wire logic [7:0]        oscillator_trim_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  wire logic rd_ok = sfr_in.rd && load_done_out;
  no_request_a: assert property (!iap_req_in |-> !iap_allow_out)
    else $error("allow without request");
  app_fence_a: assert property (iap_allow_out |-> iap_addr_in <= app_end_out)
    else $error("allow beyond application area");
  boot_write_a: assert property (boot_mode_in && iap_req_in && load_done_out
    && iap_addr_in <= app_end_out |-> iap_allow_out) else $error("boot refused");
  unmapped_read_a: assert property (rd_ok && sfr_in.addr < 8'hfe
    |=> sfr_rdata_out == 8'h00) else $error("unmapped read not zero");
  read_hold_a: assert property (!rd_ok |=> $stable(sfr_rdata_out))
    else $error("read data moved without read");
  index_back_a: assert property (sfr_in.wr && sfr_in.addr == 8'hfe
    && load_done_out ##1 !sfr_in.wr ##1 sfr_in.rd && sfr_in.addr == 8'hfe
    |=> sfr_rdata_out == $past(sfr_in.wdata, 3)) else $error("index lost");
  load_hold_a: assert property (load_done_out |=> load_done_out)
    else $error("load done dropped");
  load_time_a: assert property (!load_done_out |=> ##[0:1] load_done_out)
    else $error("options not loaded in time");
  trim_load_a: assert property ($rose(load_done_out)
    |-> oscillator_trim_out == factory_trim_in) else $error("trim not loaded");
endmodule : ora_option_access_props

// ===== verif/ora_option_access_test.sv
// testbench for the option register access block
`timescale 1ns/1ps
module ora_option_access_test;
  logic              clock_in, rst_in, boot_mode_in, iap_req_in, iap_allow_out;
  logic              load_done_out, debug_port_disable_out, wdt_out;
  logic              xtl_out, rstdis_out, lvrdis_out, boot_out;
  logic [1:0]        lvrs_out, vref_out;
  logic [3:0]        div_out;
  logic [14:0]       iap_addr_in, app_end_out;
  logic [7:0]        sfr_rdata_out, oscillator_trim_out, q;
  ora_pkg::ora_sfr_s sfr_in;
  int                errors = 0, checks = 0, cycles = 0;
  localparam logic [14:0] ENDS [4] = '{15'h7fff, 15'h7bff, 15'h77ff, 15'h6fff};
  localparam logic [3:0]  DIVS [4] = '{4'h1, 4'h2, 4'h4, 4'hc};
  ora_core_model core (.clock_in, .rdata_in(sfr_rdata_out), .sfr_out(sfr_in));
  ora_option_access dut (.clock_in, .rst_in, .sfr_in, .flash_ctm0_in(8'h25),
    .flash_ctm1_in(8'h13), .factory_trim_in(8'h5a), .boot_mode_in,
    .iap_req_in, .iap_addr_in, .sfr_rdata_out, .iap_allow_out, .load_done_out,
    .debug_port_disable_out, .boot_from_loader_out(boot_out), .app_end_out,
    .oscillator_trim_out, .clock_divide_out(div_out),
    .crystal_enable_out(xtl_out), .watchdog_enable_option_out(wdt_out),
    .ext_reset_disable_out(rstdis_out), .lvr_disable_out(lvrdis_out),
    .lvr_level_out(lvrs_out), .vref_select_out(vref_out));
  task automatic check(input logic [14:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, d);
    core.access(1'b1, a, d, q);
  endtask : wr
  task automatic rc(input logic [7:0] a, e);
    core.access(1'b0, a, 8'h00, q);
    check({7'h00, q}, {7'h00, e});
  endtask : rc
  task automatic complete_run;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    rst_in = 1'b1;
    boot_mode_in = 1'b0;
    iap_req_in = 1'b1;
    iap_addr_in = 15'h7c00;
    repeat (6) @(negedge clock_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clock_in);
    check({14'h0, load_done_out}, 15'h1);
    rc(8'hfe, 8'h00);
    wr(8'hfe, 8'hc1);
    rc(8'hff, 8'h25);
    check({6'h0, xtl_out, rstdis_out, lvrdis_out, lvrs_out, div_out},
          {6'h0, 3'b001, 2'b01, 4'h4});
    wr(8'hff, 8'ha5);
    check({14'h0, wdt_out}, 15'h1);
    for (int j = 0; j < 4; j++) begin
      wr(8'hff, {2'b01, j[1:0], 4'h8});
      check({11'h0, div_out}, {11'h0, DIVS[j]});
      check({9'h0, wdt_out, xtl_out, rstdis_out, lvrdis_out, lvrs_out},
            15'h0018);
    end
    rc(8'h80, 8'h00);
    wr(8'hfe, 8'hc2);
    rc(8'hff, 8'h13);
    for (int i = 0; i < 4; i++) begin
      wr(8'hff, {3'h0, i[0], 2'b00, i[1:0]});
      check(app_end_out, ENDS[i]);
      check({14'h0, debug_port_disable_out}, {14'h0, i[0]});
    end
    for (int r = 0; r < 4; r++) begin
      wr(8'hff, {4'h0, r[1:0], 2'b00});
      iap_addr_in = 15'h7c00;
      #1 check({14'h0, iap_allow_out}, {14'h0, r != 0});
      iap_addr_in = 15'h7bff;
      #1 check({14'h0, iap_allow_out}, {14'h0, r[1]});
    end
    wr(8'hff, 8'he1);
    check({12'h0, boot_out, vref_out}, 15'h0007);
    boot_mode_in = 1'b1;
    #1 check({14'h0, iap_allow_out}, 15'h1);
    iap_addr_in = 15'h7c00;
    #1 check({14'h0, iap_allow_out}, 15'h0);
    wr(8'hfe, 8'h83);
    rc(8'hfe, 8'h83);
    rc(8'hff, 8'h5a);
    wr(8'hff, 8'h5b);
    check({7'h00, oscillator_trim_out}, 15'h005b);
    rc(8'hff, 8'h5b);
    rst_in = 1'b1;
    @(negedge clock_in);
    rst_in = 1'b0;
    repeat (2) @(negedge clock_in);
    check({7'h00, oscillator_trim_out}, 15'h005a);
    rc(8'hfe, 8'h00);
    complete_run();
  end
endmodule : ora_option_access_test
bind ora_option_access ora_option_access_props props (.clock_in, .rst_in,
  .sfr_in, .boot_mode_in, .iap_req_in, .iap_addr_in, .factory_trim_in,
  .sfr_rdata_out, .iap_allow_out, .load_done_out, .app_end_out,
  .oscillator_trim_out);
